// ==== wwd_top.sv ====
// windowed watchdog control registers, counter and window check
`default_nettype none
module wwd_top (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic LOW_FREQ_OSC,
	input wire logic MID_FREQ_OSC,
	input wire logic SECONDARY_OSC,
	input wire logic WATCHDOG_CLEAR_INSTR,
	input wire logic [4:0] PERIOD_DEFAULT_CFG,
	input wire logic [2:0] CLOCK_SOURCE_DEFAULT_CFG,
	input wire logic [2:0] WINDOW_DEFAULT_CFG,
	input wire logic [1:0] WATCHDOG_MODE_CFG,
	output logic WDT_RESET,
	output logic WINDOW_VIOLATION,
	output logic WDT_ACTIVE
);
	wwd_pkg::wwd_bus_t bus_r;
	wwd_pkg::wwd_bus_t bus_nxt;
	logic loaded_r;
	logic [4:0] period_select_r;
	logic soft_enable_r;
	logic [2:0] clock_source_select_r;
	logic [2:0] window_select_r;
	logic armed_r;
	logic osc_prev_r;
	logic [7:0] rdata_r;
	logic wdt_reset_r;
	logic violation_r;
	logic active_r;
	logic req;
	logic acc;
	logic wr_lane;
	logic wr_period;
	logic wr_clkwin;
	logic rd_period;
	logic osc_sel;
	logic tick;
	logic [4:0] exp;
	logic [2:0] eff_window;
	logic windowed;
	logic active;
	logic win_open;
	logic violation;
	logic valid_clear;
	logic count_clear;
	logic timeout;
	logic [wwd_pkg::TOTAL_W-1:0] count;
	logic [7:0] rd_value;

	// bus handshake: one wait cycle, then the answer
	assign req = AVS_READ || AVS_WRITE;
	assign acc = req && (bus_r == wwd_pkg::WWD_BUS_ACK);
	assign AVS_WAITREQUEST = req && (bus_r != wwd_pkg::WWD_BUS_ACK);
	assign AVS_READDATA = {24'h000000, rdata_r};
	assign wr_lane = acc && AVS_WRITE && AVS_BYTEENABLE[0];
	assign wr_period = wr_lane && (AVS_ADDRESS == wwd_pkg::OFS_PERIOD);
	assign wr_clkwin = wr_lane && (AVS_ADDRESS == wwd_pkg::OFS_CLKWIN);
	assign rd_period = acc && AVS_READ && (AVS_ADDRESS == wwd_pkg::OFS_PERIOD);

	always_comb begin
		bus_nxt = bus_r;
		case (bus_r)
			wwd_pkg::WWD_BUS_IDLE: begin
				if (req) begin
					bus_nxt = wwd_pkg::WWD_BUS_ACK;
				end
			end
			wwd_pkg::WWD_BUS_ACK: begin
				bus_nxt = wwd_pkg::WWD_BUS_IDLE;
			end
			default: begin
				bus_nxt = wwd_pkg::WWD_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bus_r <= wwd_pkg::WWD_BUS_IDLE;
		end else if (CE) begin
			bus_r <= bus_nxt;
		end
	end

	always_comb begin
		rd_value = 8'h00;
		case (AVS_ADDRESS)
			wwd_pkg::OFS_PERIOD: begin
				rd_value[wwd_pkg::PER_MSB:wwd_pkg::PER_LSB] = period_select_r;
				rd_value[wwd_pkg::SOFT_EN_BIT] = soft_enable_r;
			end
			wwd_pkg::OFS_CLKWIN: begin
				rd_value[wwd_pkg::CS_MSB:wwd_pkg::CS_LSB] = clock_source_select_r;
				rd_value[wwd_pkg::WIN_MSB:wwd_pkg::WIN_LSB] = window_select_r;
			end
			wwd_pkg::OFS_PS_LOW: begin
				rd_value = count[7:0];
			end
			wwd_pkg::OFS_PS_HIGH: begin
				rd_value = count[15:8];
			end
			wwd_pkg::OFS_STATUS: begin
				rd_value[wwd_pkg::ST_PS_MSB:0] = count[wwd_pkg::PS_W-1:16];
				rd_value[wwd_pkg::ST_ARMED_BIT] = armed_r;
				rd_value[wwd_pkg::ST_CNT_MSB:wwd_pkg::ST_CNT_LSB] =
					count[wwd_pkg::PS_W+3:wwd_pkg::PS_W];
			end
			default: begin
				rd_value = 8'h00;
			end
		endcase
	end

	// read data captured in the wait cycle, stands in the answer cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_r <= 8'h00;
		end else if (CE) begin
			if (AVS_READ && bus_r == wwd_pkg::WWD_BUS_IDLE) begin
				rdata_r <= rd_value;
			end
		end
	end

	// selectors load from the defaults at the first enabled edge after reset
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			loaded_r <= 1'b0;
		end else if (CE) begin
			loaded_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			period_select_r <= wwd_pkg::PER_FALLBACK;
		end else if (CE) begin
			if (!loaded_r) begin
				if (PERIOD_DEFAULT_CFG == wwd_pkg::PER_OPEN) begin
					period_select_r <= wwd_pkg::PER_FALLBACK;
				end else begin
					period_select_r <= PERIOD_DEFAULT_CFG;
				end
			end else if (wr_period && PERIOD_DEFAULT_CFG == wwd_pkg::PER_OPEN) begin
				period_select_r <= AVS_WRITEDATA[wwd_pkg::PER_MSB:wwd_pkg::PER_LSB];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			soft_enable_r <= wwd_pkg::SOFT_EN_RST;
		end else if (CE) begin
			if (wr_period) begin
				soft_enable_r <= AVS_WRITEDATA[wwd_pkg::SOFT_EN_BIT];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			clock_source_select_r <= wwd_pkg::CS_FALLBACK;
		end else if (CE) begin
			if (!loaded_r) begin
				if (CLOCK_SOURCE_DEFAULT_CFG == wwd_pkg::CS_OPEN) begin
					clock_source_select_r <= wwd_pkg::CS_FALLBACK;
				end else begin
					clock_source_select_r <= CLOCK_SOURCE_DEFAULT_CFG;
				end
			end else if (wr_clkwin && CLOCK_SOURCE_DEFAULT_CFG == wwd_pkg::CS_OPEN) begin
				clock_source_select_r <= AVS_WRITEDATA[wwd_pkg::CS_MSB:wwd_pkg::CS_LSB];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			window_select_r <= wwd_pkg::WIN_OPEN;
		end else if (CE) begin
			if (!loaded_r) begin
				window_select_r <= WINDOW_DEFAULT_CFG;
			end else if (wr_clkwin && WINDOW_DEFAULT_CFG == wwd_pkg::WIN_OPEN) begin
				window_select_r <= AVS_WRITEDATA[wwd_pkg::WIN_MSB:wwd_pkg::WIN_LSB];
			end
		end
	end

	// time base select, reserved codes give no ticks
	always_comb begin
		case (clock_source_select_r)
			wwd_pkg::CS_LOW: osc_sel = LOW_FREQ_OSC;
			wwd_pkg::CS_MID: osc_sel = MID_FREQ_OSC;
			wwd_pkg::CS_SEC: osc_sel = SECONDARY_OSC;
			default: osc_sel = 1'b0;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			osc_prev_r <= 1'b0;
		end else if (CE) begin
			osc_prev_r <= osc_sel;
		end
	end

	assign tick = osc_sel && !osc_prev_r;

	// ratio exponent is code plus five, five for reserved codes above 18
	assign exp = (period_select_r > wwd_pkg::PER_MAX) ? wwd_pkg::EXP_MIN :
		period_select_r + wwd_pkg::EXP_MIN;

	assign eff_window = (WINDOW_DEFAULT_CFG == wwd_pkg::WIN_OPEN) ? window_select_r :
		WINDOW_DEFAULT_CFG;
	assign windowed = (eff_window != wwd_pkg::WIN_OPEN);

	assign active = WATCHDOG_MODE_CFG[1] ||
		(WATCHDOG_MODE_CFG == wwd_pkg::MODE_SOFT && soft_enable_r);

	assign violation = WATCHDOG_CLEAR_INSTR && active && windowed && (!armed_r || !win_open);
	assign valid_clear = WATCHDOG_CLEAR_INSTR && !violation;
	assign count_clear = !active || valid_clear || violation || wr_period || wr_clkwin;

	wwd_count u_count (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.tick(tick),
		.clear(count_clear),
		.exp(exp),
		.count(count),
		.timeout(timeout)
	);

	wwd_window u_window (
		.count(count),
		.exp(exp),
		.win(eff_window),
		.open(win_open)
	);

	// arm on period read, set wins over clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			armed_r <= 1'b0;
		end else if (CE) begin
			if (rd_period) begin
				armed_r <= 1'b1;
			end else if (WATCHDOG_CLEAR_INSTR) begin
				armed_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wdt_reset_r <= 1'b0;
			violation_r <= 1'b0;
			active_r <= 1'b0;
		end else if (CE) begin
			wdt_reset_r <= violation || (timeout && active);
			violation_r <= violation;
			active_r <= active;
		end
	end

	assign WDT_RESET = wdt_reset_r;
	assign WINDOW_VIOLATION = violation_r;
	assign WDT_ACTIVE = active_r;

	chk_reserved_period: assert property (@(posedge CLK) disable iff (RST)
		period_select_r > wwd_pkg::PER_MAX |-> exp == wwd_pkg::EXP_MIN)
		else $error("reserved period code not at minimum ratio");

	chk_period_lock: assert property (@(posedge CLK) disable iff (RST)
		CE && loaded_r && PERIOD_DEFAULT_CFG != wwd_pkg::PER_OPEN
		|=> $stable(period_select_r))
		else $error("locked period selector changed");

	chk_source_lock: assert property (@(posedge CLK) disable iff (RST)
		CE && loaded_r && CLOCK_SOURCE_DEFAULT_CFG != wwd_pkg::CS_OPEN
		|=> $stable(clock_source_select_r))
		else $error("locked clock source changed");

	chk_window_lock: assert property (@(posedge CLK) disable iff (RST)
		CE && loaded_r && WINDOW_DEFAULT_CFG != wwd_pkg::WIN_OPEN
		|=> $stable(window_select_r))
		else $error("locked window selector changed");

	chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
		AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:7] == '0 &&
		(AVS_ADDRESS != wwd_pkg::OFS_PERIOD || AVS_READDATA[6] == 1'b0) &&
		(AVS_ADDRESS != wwd_pkg::OFS_CLKWIN || AVS_READDATA[3] == 1'b0))
		else $error("unimplemented bit read as one");

	chk_arm_on_read: assert property (@(posedge CLK) disable iff (RST)
		CE && rd_period |=> armed_r)
		else $error("period read did not arm");

	chk_violation_reset: assert property (@(posedge CLK) disable iff (RST)
		CE && WATCHDOG_CLEAR_INSTR && active && windowed && !armed_r
		|=> WDT_RESET && WINDOW_VIOLATION)
		else $error("unarmed clear did not reset");

	chk_write_clears: assert property (@(posedge CLK) disable iff (RST)
		CE && (wr_period || wr_clkwin) |=> count == '0)
		else $error("control write did not clear counter");

	chk_status_view: assert property (@(posedge CLK) disable iff (RST)
		CE && AVS_READ && bus_r == wwd_pkg::WWD_BUS_IDLE &&
		AVS_ADDRESS == wwd_pkg::OFS_STATUS |=> AVS_READDATA[2] == $past(armed_r))
		else $error("status armed bit wrong");
endmodule : wwd_top
`default_nettype wire

// ==== wwd_pkg.sv ====
// constants and types for the windowed watchdog control block
// Operation
// - period code sets ratio 1:32 doubling per step
// - reserved period codes act as 1:32
// - period resets from default, 11111 gives 01011
// - period writable only when default is 11111
// - soft enable counts only in mode 01
// - clock source picks low, mid or secondary oscillator
// - default 111 resets clock source to 000
// - clock source writable only when default is 111
// - window code sets open share in eighths
// - window selector resets from window default
// - window writable only when default is 111
// - prescale count readable over three registers
// - status bits 6..3 show watchdog counter
// - status bit 2 shows armed state
// - unimplemented bits read as zero
// - reading period register arms the watchdog
// - early or unarmed clear causes watchdog reset when window is not 111
// - control register writes clear counter and prescaler
// - window default rules unless it is 111
`default_nettype none
package wwd_pkg;
	localparam logic [4:0] OFS_PERIOD = 5'h00;
	localparam logic [4:0] OFS_CLKWIN = 5'h04;
	localparam logic [4:0] OFS_PS_LOW = 5'h08;
	localparam logic [4:0] OFS_PS_HIGH = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam int SOFT_EN_BIT = 0;
	localparam int PER_LSB = 1;
	localparam int PER_MSB = 5;
	localparam int CS_LSB = 4;
	localparam int CS_MSB = 6;
	localparam int WIN_LSB = 0;
	localparam int WIN_MSB = 2;
	localparam int ST_PS_MSB = 1;
	localparam int ST_ARMED_BIT = 2;
	localparam int ST_CNT_LSB = 3;
	localparam int ST_CNT_MSB = 6;
	localparam int PS_W = 18;
	localparam int CNT_W = 5;
	localparam int TOTAL_W = 23;
	localparam logic [4:0] PER_MAX = 5'h12;
	localparam logic [4:0] PER_OPEN = 5'h1F;
	localparam logic [4:0] PER_FALLBACK = 5'h0B;
	localparam logic [4:0] EXP_MIN = 5'h05;
	localparam logic [2:0] CS_OPEN = 3'h7;
	localparam logic [2:0] CS_FALLBACK = 3'h0;
	localparam logic [2:0] CS_LOW = 3'h0;
	localparam logic [2:0] CS_MID = 3'h1;
	localparam logic [2:0] CS_SEC = 3'h2;
	localparam logic [2:0] WIN_OPEN = 3'h7;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic SOFT_EN_RST = 1'b0;
	typedef enum logic [1:0] {
		WWD_BUS_IDLE = 2'b00,
		WWD_BUS_ACK = 2'b01
	} wwd_bus_t;
endpackage : wwd_pkg
`default_nettype wire

// ==== wwd_count.sv ====
// combined prescale and watchdog counter with time-out detect
`default_nettype none
module wwd_count (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic clear,
	input wire logic [4:0] exp,
	output logic [wwd_pkg::TOTAL_W-1:0] count,
	output logic timeout
);
	logic [wwd_pkg::TOTAL_W-1:0] count_r;
	logic [wwd_pkg::TOTAL_W-1:0] mask;

	assign mask = ~({wwd_pkg::TOTAL_W{1'b1}} << exp);
	assign count = count_r;
	assign timeout = tick && !clear && (count_r == mask);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_r <= '0;
		end else if (ce) begin
			if (clear || timeout) begin
				count_r <= '0;
			end else if (tick) begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	chk_timeout_wraps: assert property (@(posedge clk) disable iff (rst)
		ce && timeout |=> count_r == '0)
		else $error("counter did not wrap after time-out");
endmodule : wwd_count
`default_nettype wire

// ==== wwd_window.sv ====
// window comparator: open when elapsed eighths reach the delay
`default_nettype none
module wwd_window (
	input wire logic [wwd_pkg::TOTAL_W-1:0] count,
	input wire logic [4:0] exp,
	input wire logic [2:0] win,
	output logic open
);
	logic [wwd_pkg::TOTAL_W-1:0] shifted;
	logic [2:0] eighths;

	assign shifted = count >> (exp - 5'd3);
	assign eighths = shifted[2:0];
	// delay is seven minus code eighths
	assign open = (eighths >= ~win);
endmodule : wwd_window
`default_nettype wire

// ==== tb_windowed_watchdog_control.sv ====
// self-checking bench for the windowed watchdog control registers
`default_nettype none
module tb_windowed_watchdog_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic CE = 1'b1;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h00000000;
	logic [3:0] AVS_BYTEENABLE = 4'h0;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic [2:0] osc = 3'h0;
	logic CLR = 1'b0;
	logic [4:0] PER_CFG = 5'h1F;
	logic [2:0] CS_CFG = 3'h7;
	logic [2:0] WIN_CFG = 3'h7;
	logic [1:0] MODE_CFG = 2'h1;
	logic WDT_RESET;
	logic WINDOW_VIOLATION;
	logic WDT_ACTIVE;
	int mismatches = 0;
	int checks_done = 0;
	int rst_cnt = 0;
	int vio_cnt = 0;
	int e_rst = 0;
	int e_vio = 0;
	wwd_top u_dut (.CLK(CLK), .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .LOW_FREQ_OSC(osc[0]), .MID_FREQ_OSC(osc[1]),
		.SECONDARY_OSC(osc[2]), .WATCHDOG_CLEAR_INSTR(CLR),
		.PERIOD_DEFAULT_CFG(PER_CFG), .CLOCK_SOURCE_DEFAULT_CFG(CS_CFG),
		.WINDOW_DEFAULT_CFG(WIN_CFG), .WATCHDOG_MODE_CFG(MODE_CFG),
		.WDT_RESET(WDT_RESET), .WINDOW_VIOLATION(WINDOW_VIOLATION), .WDT_ACTIVE(WDT_ACTIVE));
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	// counts output pulses seen at each rising edge
	always @(posedge CLK) begin
		if (WDT_RESET === 1'b1) rst_cnt++;
		if (WINDOW_VIOLATION === 1'b1) vio_cnt++;
	end
	task automatic summarize();
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask
	// one request, held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_BYTEENABLE <= be;
		if (wr) AVS_WRITE <= 1'b1;
		else AVS_READ <= 1'b1;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0 && n < 20) begin
			n++;
			@(posedge CLK);
		end
		if (AVS_WAITREQUEST !== 1'b0) begin
			$display("[FAIL] waitrequest expected 0 seen 1");
			mismatches++;
			summarize();
		end
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask
	task automatic rchk(input string name, input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		check(name, q, {24'h000000, e});
	endtask
	task automatic do_reset(input logic [4:0] p, input logic [2:0] c, input logic [2:0] w,
		input logic [1:0] m);
		@(posedge CLK);
		RST <= 1'b1;
		PER_CFG <= p;
		CS_CFG <= c;
		WIN_CFG <= w;
		MODE_CFG <= m;
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask
	task automatic tick(input int s, input int n);
		repeat (n) begin
			@(posedge CLK);
			osc[s] <= 1'b1;
			@(posedge CLK);
			osc[s] <= 1'b0;
		end
		repeat (4) @(posedge CLK);
	endtask
	task automatic clear_pulse();
		@(posedge CLK);
		CLR <= 1'b1;
		@(posedge CLK);
		CLR <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask
	task automatic pulses();
		check("wdt_reset pulses", 32'(rst_cnt), 32'(e_rst));
		check("violation pulses", 32'(vio_cnt), 32'(e_vio));
	endtask
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		do_reset(5'h1F, 3'h7, 3'h7, 2'h1);
		rchk("status reset", wwd_pkg::OFS_STATUS, 8'h00);
		rchk("period reset", wwd_pkg::OFS_PERIOD, 8'h16);
		rchk("clkwin reset", wwd_pkg::OFS_CLKWIN, 8'h07);
		rchk("ps low reset", wwd_pkg::OFS_PS_LOW, 8'h00);
		rchk("ps high reset", wwd_pkg::OFS_PS_HIGH, 8'h00);
		rchk("unmapped", 5'h14, 8'h00);
		check("active soft off", {31'h0, WDT_ACTIVE}, 32'h0);
		wr(wwd_pkg::OFS_PERIOD, 8'hFF, 4'h0);
		rchk("period no byte", wwd_pkg::OFS_PERIOD, 8'h16);
		wr(wwd_pkg::OFS_PERIOD, 8'hFF);
		rchk("period open", wwd_pkg::OFS_PERIOD, 8'h3F);
		wr(wwd_pkg::OFS_CLKWIN, 8'hFF);
		rchk("clkwin open", wwd_pkg::OFS_CLKWIN, 8'h77);
		wr(wwd_pkg::OFS_PERIOD, 8'h01);
		repeat (3) @(posedge CLK);
		check("active soft on", {31'h0, WDT_ACTIVE}, 32'h1);
		for (int s = 0; s < 4; s++) begin
			wr(wwd_pkg::OFS_CLKWIN, {1'b0, 3'(s), 4'h7});
			for (int k = 0; k < 3; k++) tick(k, 1);
			rchk("source ticks", wwd_pkg::OFS_PS_LOW, (s < 3) ? 8'h01 : 8'h00);
		end
		wr(wwd_pkg::OFS_CLKWIN, 8'h07);
		tick(0, 31);
		rchk("ps count 31", wwd_pkg::OFS_PS_LOW, 8'h1F);
		pulses();
		tick(0, 1);
		e_rst++;
		pulses();
		rchk("ps after timeout", wwd_pkg::OFS_PS_LOW, 8'h00);
		wr(wwd_pkg::OFS_PERIOD, 8'h27);
		rchk("period reserved", wwd_pkg::OFS_PERIOD, 8'h27);
		tick(0, 31);
		pulses();
		tick(0, 1);
		e_rst++;
		pulses();
		tick(0, 10);
		rchk("ps count 10", wwd_pkg::OFS_PS_LOW, 8'h0A);
		CE <= 1'b0;
		tick(0, 3);
		CE <= 1'b1;
		rchk("ps frozen", wwd_pkg::OFS_PS_LOW, 8'h0A);
		wr(wwd_pkg::OFS_CLKWIN, 8'h00);
		rchk("ps after write", wwd_pkg::OFS_PS_LOW, 8'h00);
		clear_pulse();
		e_vio++;
		e_rst++;
		pulses();
		rchk("arm read", wwd_pkg::OFS_PERIOD, 8'h27);
		rchk("armed flag", wwd_pkg::OFS_STATUS, 8'h04);
		clear_pulse();
		e_vio++;
		e_rst++;
		pulses();
		for (int t = 27; t < 29; t++) begin
			wr(wwd_pkg::OFS_CLKWIN, 8'h00);
			rchk("arm read", wwd_pkg::OFS_PERIOD, 8'h27);
			tick(0, t);
			clear_pulse();
			if (t == 27) e_vio++;
			if (t == 27) e_rst++;
			pulses();
		end
		rchk("status after clear", wwd_pkg::OFS_STATUS, 8'h00);
		rchk("ps after clear", wwd_pkg::OFS_PS_LOW, 8'h00);
		tick(0, 28);
		clear_pulse();
		e_vio++;
		e_rst++;
		pulses();
		do_reset(5'h03, 3'h2, 3'h4, 2'h2);
		rchk("period locked reset", wwd_pkg::OFS_PERIOD, 8'h06);
		rchk("clkwin locked reset", wwd_pkg::OFS_CLKWIN, 8'h24);
		wr(wwd_pkg::OFS_PERIOD, 8'hFF);
		wr(wwd_pkg::OFS_CLKWIN, 8'hFF);
		rchk("period locked", wwd_pkg::OFS_PERIOD, 8'h07);
		rchk("clkwin locked", wwd_pkg::OFS_CLKWIN, 8'h24);
		check("active mode 1x", {31'h0, WDT_ACTIVE}, 32'h1);
		clear_pulse();
		e_vio++;
		e_rst++;
		pulses();
		do_reset(5'h03, 3'h2, 3'h4, 2'h0);
		wr(wwd_pkg::OFS_PERIOD, 8'h01);
		repeat (3) @(posedge CLK);
		check("active mode 00", {31'h0, WDT_ACTIVE}, 32'h0);
		summarize();
	end
endmodule // tb_windowed_watchdog_control
`default_nettype wire
